// ---- core/pwss_pkg.sv ----
// Package for the potentiometer wiper two-wire slave.
// Assumes a 200 MHz core clock; the bus lines arrive from outside that domain.
package pwss_pkg;
  localparam int          CLK_PERIOD_PS          = 5000;
  localparam int          GLITCH_FILTER_TIME_NS  = 50;
  localparam int          GLITCH_CYCLES          = (GLITCH_FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          SETTLE_MIN_NS          = 5000;
  localparam int          SETTLE_CYCLES          = (SETTLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          WIPER_W                = 7;
  localparam logic [6:0]  WIPER_RESET            = 7'h40;
  localparam logic [7:0]  REG_ADDR_WIPER         = 8'h00;
  localparam logic [6:0]  SLAVE_ADDR_DEFAULT     = 7'h2A;
  localparam logic [3:0]  BIT_LAST               = 4'h7;
  localparam logic [3:0]  BIT_ACK                = 4'h8;

  typedef enum logic [2:0]
  {
    PWSS_IDLE  = 3'b000,
    PWSS_ADDR  = 3'b001,
    PWSS_REG   = 3'b010,
    PWSS_DATA  = 3'b011,
    PWSS_READ  = 3'b100,
    PWSS_WAIT  = 3'b101
  } pwss_state_t;
endpackage

// ---- core/pwss_slave.sv ----
// Two-wire serial slave front end holding the wiper position of a digital potentiometer.
// Assumes scl_i and sda_i come from pins; sda is open drain, driven low while sda_oe_o is high.
// Notes on behaviour
// [RULE1] Master starts a transfer only while the bus is idle.
// [RULE2] Data changes only while clock is low; stable while high.
// [RULE3] A data edge while clock is high is start or stop, never data.
// [RULE4] Master makes the clock; this slave never drives it.
// [RULE5] Start is data falling while clock is high.
// [RULE6] All activity is ignored until a start has been seen.
// [RULE7] Stop is data rising while clock is high.
// [RULE8] Master closes every read or write with a stop.
// [RULE9] Receiver acknowledges eight bits by holding data low for the ninth clock.
// [RULE10] Address byte is acknowledged only when it matches our slave address.
// [RULE11] Once addressed for write, every further byte is acknowledged.
// [RULE12] Read mode shifts eight bits, releases data, samples master acknowledge.
// [RULE13] Master acknowledge after a read byte makes the slave send more data.
// [RULE14] No acknowledge ends sending; slave idles until a stop.
// [RULE15] Master waits up to 1 ms after power before a read.
// [RULE16] Master waits up to 1 ms after power before a write.
// [RULE17] Wiper reaches new position 5 to 10 us after a write.
// [RULE18] Wiper settles at initial position 5 to 10 us after power up.
// [RULE19] Pulses up to 50 ns on clock or data are suppressed.
// [RULE20] First byte is seven address bits MSB first, then read high, write low.
// [RULE21] Write: address, register byte zero, one data byte, stop; update after third byte.
// [RULE22] Wiper holds seven bits; data MSB ignored on write, read back as zero.
// [RULE23] Wiper register loads midscale at power up.
// [RULE24] Clock and data are synchronised and filtered before edge detection.
`timescale 1ns/1ps
module pwss_slave
#(
  parameter logic [6:0] SLAVE_ADDR = pwss_pkg::SLAVE_ADDR_DEFAULT, // Arbitrary value
  parameter int         GLITCH_CYC = pwss_pkg::GLITCH_CYCLES,
  parameter int         SETTLE_CYC = pwss_pkg::SETTLE_CYCLES
)
(
  input  wire logic       clk_i,
  input  wire logic       srst_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [6:0]      wiper_position_o,
  output logic            wiper_settled_o,
  output logic            busy_o
);
  // Synchronisers and filters
  logic [2:0]  scl_sync_reg;
  logic [2:0]  scl_sync_next;
  logic [2:0]  sda_sync_reg;
  logic [2:0]  sda_sync_next;
  logic        scl_f_reg;
  logic        scl_f_next;
  logic        sda_f_reg;
  logic        sda_f_next;
  logic [7:0]  scl_cnt_reg;
  logic [7:0]  scl_cnt_next;
  logic [7:0]  sda_cnt_reg;
  logic [7:0]  sda_cnt_next;

  function automatic logic [7:0] filt_cnt(input logic agree, input logic differs, input logic [7:0] cnt);
    if (!agree || !differs)
      filt_cnt = 8'h00;
    else
      filt_cnt = cnt + 8'h01;
  endfunction

  always_comb
  begin
    scl_sync_next = {scl_sync_reg[1:0], scl_i};
    sda_sync_next = {sda_sync_reg[1:0], sda_i};
    // Advance counts only when second and third stages agree [RULE24]
    scl_cnt_next = filt_cnt(scl_sync_reg[1] == scl_sync_reg[2], scl_sync_reg[2] != scl_f_reg, scl_cnt_reg);
    sda_cnt_next = filt_cnt(sda_sync_reg[1] == sda_sync_reg[2], sda_sync_reg[2] != sda_f_reg, sda_cnt_reg);
    scl_f_next = scl_f_reg;
    sda_f_next = sda_f_reg;
    // Level must persist past the noise window before it is accepted [RULE19]
    if (scl_cnt_next >= 8'(GLITCH_CYC))
    begin
      scl_f_next   = scl_sync_reg[2];
      scl_cnt_next = 8'h00;
    end
    if (sda_cnt_next >= 8'(GLITCH_CYC))
    begin
      sda_f_next   = sda_sync_reg[2];
      sda_cnt_next = 8'h00;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_f_reg    <= 1'b1;
      sda_f_reg    <= 1'b1;
      scl_cnt_reg  <= 8'h00;
      sda_cnt_reg  <= 8'h00;
    end
    else if (ce_i)
    begin
      scl_sync_reg <= scl_sync_next;
      sda_sync_reg <= sda_sync_next;
      scl_f_reg    <= scl_f_next;
      sda_f_reg    <= sda_f_next;
      scl_cnt_reg  <= scl_cnt_next;
      sda_cnt_reg  <= sda_cnt_next;
    end
  end

  // Edge and condition detection on filtered lines
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end
    else if (ce_i)
    begin
      scl_d_reg <= scl_f_reg;
      sda_d_reg <= sda_f_reg;
    end
  end

  assign scl_rise  = scl_f_reg && !scl_d_reg;
  assign scl_fall  = !scl_f_reg && scl_d_reg;
  assign start_det = scl_f_reg && scl_d_reg && sda_d_reg && !sda_f_reg; // [RULE3] [RULE5]
  assign stop_det  = scl_f_reg && scl_d_reg && !sda_d_reg && sda_f_reg; // [RULE3] [RULE7]

  // Protocol engine
  pwss_pkg::pwss_state_t state_reg;
  pwss_pkg::pwss_state_t state_next;
  logic [3:0]  bit_reg;
  logic [3:0]  bit_next;
  logic [7:0]  shift_reg;
  logic [7:0]  shift_next;
  logic        ack_ok_reg;
  logic        ack_ok_next;
  logic        sda_oe_reg;
  logic        sda_oe_next;
  logic [6:0]  wiper_reg;
  logic [6:0]  wiper_next;
  logic        busy_reg;
  logic        busy_next;
  logic        wr_pulse;

  always_comb
  begin
    state_next  = state_reg;
    bit_next    = bit_reg;
    shift_next  = shift_reg;
    ack_ok_next = ack_ok_reg;
    sda_oe_next = sda_oe_reg;
    wiper_next  = wiper_reg;
    busy_next   = busy_reg;
    wr_pulse    = 1'b0;
    if (stop_det)
    begin
      state_next  = pwss_pkg::PWSS_IDLE;
      sda_oe_next = 1'b0;
      busy_next   = 1'b0;
    end
    else if (start_det)
    begin
      // Repeated start reopens address phase from any state
      state_next  = pwss_pkg::PWSS_ADDR;
      // Clock fall that closes the start must not count as a bit
      bit_next    = 4'hF;
      sda_oe_next = 1'b0;
      busy_next   = 1'b1;
    end
    else if (state_reg != pwss_pkg::PWSS_IDLE && state_reg != pwss_pkg::PWSS_WAIT) // [RULE6]
    begin
      if (scl_rise)
      begin
        // Sample only at clock rise; data held while high [RULE2]
        if (bit_reg <= pwss_pkg::BIT_LAST && state_reg != pwss_pkg::PWSS_READ)
          shift_next = {shift_reg[6:0], sda_f_reg};
        if (bit_reg == pwss_pkg::BIT_ACK && state_reg == pwss_pkg::PWSS_READ)
          ack_ok_next = !sda_f_reg; // [RULE12]
      end
      else if (scl_fall)
      begin
        bit_next    = bit_reg + 4'h1;
        sda_oe_next = 1'b0;
        if (bit_reg == pwss_pkg::BIT_LAST)
        begin
          unique case (state_reg)
            pwss_pkg::PWSS_ADDR:
            begin
              if (shift_reg[7:1] == SLAVE_ADDR) // [RULE10] [RULE20]
                sda_oe_next = 1'b1; // [RULE9]
              else
                state_next = pwss_pkg::PWSS_WAIT;
            end
            pwss_pkg::PWSS_REG:
            begin
              sda_oe_next = 1'b1; // [RULE11]
              ack_ok_next = (shift_reg == pwss_pkg::REG_ADDR_WIPER);
            end
            pwss_pkg::PWSS_DATA:
            begin
              sda_oe_next = 1'b1; // [RULE11]
              if (ack_ok_reg)
              begin
                wiper_next = shift_reg[6:0]; // [RULE21] [RULE22]
                wr_pulse   = 1'b1; // [RULE17]
              end
            end
            pwss_pkg::PWSS_READ:
              sda_oe_next = 1'b0; // [RULE12]
            default:
              state_next = pwss_pkg::PWSS_WAIT;
          endcase
        end
        else if (bit_reg == pwss_pkg::BIT_ACK)
        begin
          bit_next = 4'h0;
          unique case (state_reg)
            pwss_pkg::PWSS_ADDR:
            begin
              if (shift_reg[0])
              begin
                state_next  = pwss_pkg::PWSS_READ;
                shift_next  = {1'b0, wiper_reg};
                sda_oe_next = 1'b1; // MSB always zero [RULE22]
              end
              else
                state_next = pwss_pkg::PWSS_REG;
            end
            pwss_pkg::PWSS_REG:
              state_next = pwss_pkg::PWSS_DATA;
            pwss_pkg::PWSS_DATA:
            begin
              state_next  = pwss_pkg::PWSS_DATA; // Further bytes acked, not stored [RULE11]
              ack_ok_next = 1'b0; // One data byte per write [RULE21]
            end
            pwss_pkg::PWSS_READ:
            begin
              if (ack_ok_reg)
              begin
                shift_next  = {1'b0, wiper_reg}; // [RULE13]
                sda_oe_next = 1'b1;
              end
              else
                state_next = pwss_pkg::PWSS_WAIT; // [RULE14]
            end
            default:
              state_next = pwss_pkg::PWSS_WAIT;
          endcase
        end
        else if (state_reg == pwss_pkg::PWSS_READ)
        begin
          // Next bit out after the falling edge; low bits drive, high bits release
          shift_next  = {shift_reg[6:0], 1'b0};
          sda_oe_next = !shift_reg[6];
        end
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      state_reg  <= pwss_pkg::PWSS_IDLE;
      bit_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      ack_ok_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      wiper_reg  <= pwss_pkg::WIPER_RESET; // [RULE23]
      busy_reg   <= 1'b0;
    end
    else if (ce_i)
    begin
      state_reg  <= state_next;
      bit_reg    <= bit_next;
      shift_reg  <= shift_next;
      ack_ok_reg <= ack_ok_next;
      sda_oe_reg <= sda_oe_next;
      wiper_reg  <= wiper_next;
      busy_reg   <= busy_next;
    end
  end

  // Settling: wiper output follows register after the least settle time
  logic [15:0] settle_cnt_reg;
  logic [15:0] settle_cnt_next;
  logic [6:0]  wiper_out_reg;
  logic [6:0]  wiper_out_next;
  logic        settled_reg;
  logic        settled_next;

  always_comb
  begin
    settle_cnt_next = settle_cnt_reg;
    wiper_out_next  = wiper_out_reg;
    settled_next    = settled_reg;
    if (wr_pulse)
    begin
      settle_cnt_next = 16'h0000;
      settled_next    = 1'b0;
    end
    else if (!settled_reg)
    begin
      settle_cnt_next = settle_cnt_reg + 16'h0001;
      if (settle_cnt_next >= 16'(SETTLE_CYC))
      begin
        wiper_out_next = wiper_reg; // [RULE17] [RULE18]
        settled_next   = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      settle_cnt_reg <= 16'h0000;
      wiper_out_reg  <= pwss_pkg::WIPER_RESET;
      settled_reg    <= 1'b0;
    end
    else if (ce_i)
    begin
      settle_cnt_reg <= settle_cnt_next;
      wiper_out_reg  <= wiper_out_next;
      settled_reg    <= settled_next;
    end
  end

  assign sda_o            = 1'b0; // Open drain: only ever pulls low; clock never driven [RULE4]
  assign sda_oe_o         = sda_oe_reg;
  assign wiper_position_o = wiper_out_reg;
  assign wiper_settled_o  = settled_reg;
  assign busy_o           = busy_reg;

  a_stop_idles: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && stop_det |=> state_reg == pwss_pkg::PWSS_IDLE && !sda_oe_o) // [RULE7]
    else $error("stop did not idle the slave");

  a_start_addr: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && start_det && !stop_det |=> state_reg == pwss_pkg::PWSS_ADDR && bit_reg == 4'hF) // [RULE5]
    else $error("start did not open address phase");

  a_idle_quiet: assert property (@(posedge clk_i) disable iff (srst_i)
    state_reg == pwss_pkg::PWSS_IDLE |-> !sda_oe_o) // [RULE6]
    else $error("driving data while idle");

  a_nomatch_noack: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_reg == pwss_pkg::PWSS_ADDR && scl_fall && bit_reg == pwss_pkg::BIT_LAST
    && !start_det && !stop_det && shift_reg[7:1] != SLAVE_ADDR |=> !sda_oe_o) // [RULE10]
    else $error("acked a foreign address");

  a_write_ack: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_reg == pwss_pkg::PWSS_DATA && scl_fall && bit_reg == pwss_pkg::BIT_LAST
    && !start_det && !stop_det |=> sda_oe_o) // [RULE11]
    else $error("write byte not acknowledged");

  a_wiper_msb: assert property (@(posedge clk_i) disable iff (srst_i)
    wr_pulse && ce_i |=> wiper_reg == $past(shift_reg[6:0]) && !settled_reg) // [RULE22]
    else $error("wiper write wrong");

  a_read_release: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_reg == pwss_pkg::PWSS_READ && scl_fall && bit_reg == pwss_pkg::BIT_LAST
    && !start_det && !stop_det |=> !sda_oe_o) // [RULE12]
    else $error("read ack slot not released");

  a_nack_wait: assert property (@(posedge clk_i) disable iff (srst_i)
    ce_i && state_reg == pwss_pkg::PWSS_READ && scl_fall && bit_reg == pwss_pkg::BIT_ACK
    && !ack_ok_reg && !start_det && !stop_det |=> state_reg == pwss_pkg::PWSS_WAIT [*2]) // [RULE14]
    else $error("nack did not stop sending");
endmodule

// ---- tb/pwss_mstr.sv ----
// Two-wire bus master model facing the wiper slave.
// Assumes the core clock paces it; the data line is open drain with a pull-up.
`timescale 1ns/1ps
module pwss_mstr
(
  input  wire logic clk_i,
  input  wire logic sda_oe_i,
  output logic      scl_o,
  output logic      sda_o
);
  logic sda_drv_reg;

  // Released line reads high through the pull-up
  assign sda_o = sda_drv_reg & ~sda_oe_i;

  initial
  begin
    scl_o = 1'b1;
    sda_drv_reg = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One clock period of 25 core cycles: 13 low, 12 high
  task automatic bit_cell(input logic v, output logic s);
    wait_cyc(6);
    sda_drv_reg <= v;
    wait_cyc(7);
    scl_o <= 1'b1;
    wait_cyc(6);
    s = sda_o;
    wait_cyc(6);
    scl_o <= 1'b0;
  endtask

  // Called only with the bus idle or as a repeated start
  task automatic start_cond();
    wait_cyc(6);
    sda_drv_reg <= 1'b1;
    wait_cyc(7);
    scl_o <= 1'b1;
    wait_cyc(12);
    sda_drv_reg <= 1'b0;
    wait_cyc(12);
    scl_o <= 1'b0;
  endtask

  task automatic stop_cond();
    wait_cyc(6);
    sda_drv_reg <= 1'b0;
    wait_cyc(7);
    scl_o <= 1'b1;
    wait_cyc(12);
    sda_drv_reg <= 1'b1;
    wait_cyc(12);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cell(b[i], s);
    bit_cell(1'b1, s);
    ack = ~s;
  endtask

  task automatic recv_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cell(1'b1, s);
      b[i] = s;
    end
    bit_cell(~ack, s);
  endtask

  // Deliberate short pulse on data, too short to count as an edge
  task automatic glitch();
    sda_drv_reg <= 1'b0;
    wait_cyc(1);
    sda_drv_reg <= 1'b1;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench for the wiper two-wire slave.
// Assumes the master model drives the bus; short filter and settle counts.
`timescale 1ns/1ps
module testbench;
  localparam int         SETTLE = 60;
  localparam logic [6:0] ADDR   = pwss_pkg::SLAVE_ADDR_DEFAULT;
  logic       clk_i       = 1'b0;
  logic       srst_i      = 1'b1;
  logic       ce_i        = 1'b1;
  logic       scl;
  logic       sda;
  logic       sda_oe;
  logic       sda_val;
  logic [6:0] wiper;
  logic       settled;
  logic       busy;
  int         n_mismatch  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  always #2.5 clk_i = ~clk_i;

  pwss_slave #(.SLAVE_ADDR(ADDR), .GLITCH_CYC(2), .SETTLE_CYC(SETTLE)) i_pwss_slave
  (
    .clk_i            (clk_i),
    .srst_i           (srst_i),
    .ce_i             (ce_i),
    .scl_i            (scl),
    .sda_i            (sda),
    .sda_o            (sda_val),
    .sda_oe_o         (sda_oe),
    .wiper_position_o (wiper),
    .wiper_settled_o  (settled),
    .busy_o           (busy)
  );

  pwss_mstr i_pwss_mstr
  (
    .clk_i    (clk_i),
    .sda_oe_i (sda_oe),
    .scl_o    (scl),
    .sda_o    (sda)
  );

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard; a full run needs about 6600 cycles
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 30000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  task automatic wr_txn(input logic [6:0] ad, input logic [7:0] r, input logic [7:0] d, input logic early,
                        output logic [2:0] a);
    i_pwss_mstr.start_cond();
    i_pwss_mstr.send_byte({ad, 1'b0}, a[2]);
    i_pwss_mstr.send_byte(r, a[1]);
    a[0] = 1'b0;
    if (!early)
      i_pwss_mstr.send_byte(d, a[0]);
  endtask

  task automatic t_power();
    check("mid pos", {1'b0, wiper}, 8'h40);
    // Clock enable low must hold off settling
    ce_i <= 1'b0;
    repeat (SETTLE + 8) @(posedge clk_i);
    check("frozen settle", {7'h00, settled}, 8'h00);
    ce_i <= 1'b1;
    repeat (SETTLE - 4) @(posedge clk_i);
    check("early settle", {7'h00, settled}, 8'h00);
    repeat (8) @(posedge clk_i);
    check("power settle", {7'h00, settled}, 8'h01);
    $display("power test done");
  endtask

  task automatic t_read(input logic [7:0] exp);
    logic [2:0] a;
    logic [7:0] b0;
    logic [7:0] b1;
    int         bad;
    bad = 0;
    i_pwss_mstr.start_cond();
    i_pwss_mstr.send_byte({ADDR, 1'b0}, a[2]);
    i_pwss_mstr.send_byte(8'h00, a[1]);
    i_pwss_mstr.start_cond();
    i_pwss_mstr.send_byte({ADDR, 1'b1}, a[0]);
    i_pwss_mstr.recv_byte(1'b1, b0);
    i_pwss_mstr.recv_byte(1'b0, b1);
    repeat (12) @(posedge clk_i) if (sda_oe !== 1'b0) bad++;
    i_pwss_mstr.stop_cond();
    check("read acks", {5'h00, a}, 8'h07);
    check("read byte", b0, exp);
    check("read more", b1, exp);
    check("nack release", 8'(bad), 8'h00);
    check("drive level", {7'h00, sda_val}, 8'h00);
    $display("read test done");
  endtask

  task automatic t_write();
    logic [2:0] a;
    wr_txn(ADDR, 8'h00, 8'hD5, 1'b0, a);
    check("busy", {7'h00, busy}, 8'h01);
    check("settle low", {7'h00, settled}, 8'h00);
    check("old pos", {1'b0, wiper}, 8'h40);
    i_pwss_mstr.stop_cond();
    check("idle", {7'h00, busy}, 8'h00);
    repeat (SETTLE) @(posedge clk_i);
    check("write acks", {5'h00, a}, 8'h07);
    check("new pos", {1'b0, wiper}, 8'h55);
    check("settled", {7'h00, settled}, 8'h01);
    $display("write test done");
  endtask

  task automatic t_refuse();
    logic [2:0] a;
    logic       e;
    wr_txn(ADDR ^ 7'h01, 8'h00, 8'h11, 1'b0, a);
    i_pwss_mstr.stop_cond();
    check("foreign acks", {5'h00, a}, 8'h00);
    wr_txn(ADDR, 8'h01, 8'h22, 1'b0, a);
    i_pwss_mstr.stop_cond();
    check("reg one acks", {5'h00, a}, 8'h07);
    wr_txn(ADDR, 8'h00, 8'h33, 1'b1, a);
    i_pwss_mstr.stop_cond();
    check("abort acks", {5'h00, a}, 8'h06);
    check("abort idle", {7'h00, busy}, 8'h00);
    repeat (SETTLE + 10) @(posedge clk_i);
    check("kept pos", {1'b0, wiper}, 8'h55);
    wr_txn(ADDR, 8'h00, 8'hD5, 1'b0, a);
    i_pwss_mstr.send_byte(8'h7F, e);
    i_pwss_mstr.stop_cond();
    check("extra ack", {7'h00, e}, 8'h01);
    repeat (SETTLE + 10) @(posedge clk_i);
    check("one data byte", {1'b0, wiper}, 8'h55);
    $display("refusal test done");
  endtask

  // A false start would raise busy, so busy is watched over the whole window
  task automatic t_glitch();
    int bad;
    bad = 0;
    i_pwss_mstr.glitch();
    repeat (25) @(posedge clk_i) if (busy !== 1'b0) bad++;
    check("glitch busy", 8'(bad), 8'h00);
    $display("glitch test done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    t_power();
    t_read(8'h40);
    t_write();
    t_refuse();
    t_glitch();
    t_read(8'h55);
    test_done();
  end
endmodule
